//--- design/ufc_fifo.sv
// Synchronous FIFO store with a run-time capacity limit.
// Assumes cap is between 1 and 2**AW; clear beats push and pop.
`timescale 1ns/10ps
module ufc_fifo #(
    parameter int W = 8,
    parameter int AW = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    ufc_fifo_if.store f
);
    import ufc_pkg::*;
    logic [W-1:0] mem [0:(1<<AW)-1];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    assign f.full = (cnt_r >= f.cap);
    assign f.count = cnt_r;
    assign f.rdata = mem[rp_r];

    always_comb begin
        do_push = f.push & ~f.full & ~f.clear;
        do_pop = f.pop & (cnt_r != '0) & ~f.clear;
        wp_nxt = wp_r + AW'(do_push);
        rp_nxt = rp_r + AW'(do_pop);
        cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        if (f.clear) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage carries no reset; contents are only read below count
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wp_r] <= f.wdata;
        end
    end
endmodule : ufc_fifo

//--- design/ufc_fifo_ctrl.sv
// UART channel FIFO control, line status and DMA request outputs.
// Assumes an APB master, a receive shifter that strobes rx_valid and a
// transmit shifter that takes bytes with tx_take, all on pclk.
// Functional notes
// - FIFOs on and mask bits clear: no interrupt request, software polls.
// - Line status bit 0 high while receive FIFO holds a byte.
// - Line status bits 1-4 give overrun, parity, framing, break.
// - Line status bit 5 set when transmit FIFO is empty.
// - Line status bit 6 only when transmit FIFO and shifter empty.
// - Line status bit 7 set while any stored receive byte has error.
// - Mode 0: transmit request low while empty, high once loaded.
// - Mode 0: receive request low while any byte is held.
// - Mode 1: transmit request low below trigger, high when full.
// - Mode 1: receive request low at trigger or timeout, high empty.
// - Mode 1: transmit interrupt condition while count below trigger.
// - Mode 1: receive FIFO fills past trigger, request stays low.
// - Receive interrupt when stored count reaches receive trigger.
// - Receive trigger codes select 8, 16, 24, 28 bytes.
// - Transmit trigger field, default 16; interrupt below level.
// - Transmit trigger codes select 16, 8, 24, 30 bytes.
// - Control bit 3 picks DMA mode 0 or 1, resets to 0.
// - Control bit 2 empties transmit FIFO, then clears itself.
// - Control bit 1 empties receive FIFO, then clears itself.
// - Other control bits written only when bit 0 written as one.
`timescale 1ns/10ps
module ufc_fifo_ctrl #(
    parameter int AW = ufc_pkg::FIFO_AW
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ufc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_parity_err,
    input wire logic rx_framing_err,
    input wire logic rx_break,
    input wire logic rx_timeout,
    input wire logic tx_take,
    output logic [7:0] tx_byte,
    output logic tx_avail,
    input wire logic tx_shift_empty,
    output logic tx_dma_request_n,
    output logic rx_dma_request_n,
    output logic int_request
);
    import ufc_pkg::*;
    localparam int CW = AW + 1;

    ufc_fifo_if #(.W(8), .AW(AW)) tx_if();
    ufc_fifo_if #(.W(11), .AW(AW)) rx_if();

    ufc_fifo #(.W(8), .AW(AW)) u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .f(tx_if.store)
    );
    ufc_fifo #(.W(11), .AW(AW)) u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .f(rx_if.store)
    );

    logic fen_r, fen_nxt, dma_r, dma_nxt;
    logic [1:0] rtrig_r, rtrig_nxt, ttrig_r, ttrig_nxt;
    logic [3:0] imask_r, imask_nxt;
    logic rxclr_r, rxclr_nxt, txclr_r, txclr_nxt;
    logic ovr_r, ovr_nxt, rdok_r, rdok_nxt;
    logic txreq_n_r, txreq_n_nxt, rxreq_n_r, rxreq_n_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [CW-1:0] err_r, err_nxt;
    logic [CW-1:0] tcnt, rcnt, rtrig_lvl, ttrig_lvl;
    logic [7:0] line_status;
    logic setup, wr, rd, hit, wr_fc, mode1;
    logic rx_acc, rx_pop, rx_cond, tx_cond, rx_err_in;

    assign tcnt = tx_if.count;
    assign rcnt = rx_if.count;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign hit = (paddr == OFS_DATA) | (paddr == OFS_IMASK) |
                 (paddr == OFS_FCTRL) | (paddr == OFS_LSTAT) |
                 (paddr == OFS_LEVEL);
    assign wr_fc = wr & (paddr == OFS_FCTRL);
    assign mode1 = fen_r & dma_r;
    // Zero wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_r;

    always_comb begin
        case (rtrig_r)
            2'b00: rtrig_lvl = CW'(RTRIG_00);
            2'b01: rtrig_lvl = CW'(RTRIG_01);
            2'b10: rtrig_lvl = CW'(RTRIG_10);
            2'b11: rtrig_lvl = CW'(RTRIG_11);
            default: rtrig_lvl = CW'(RTRIG_00);
        endcase
        case (ttrig_r)
            2'b00: ttrig_lvl = CW'(TTRIG_00);
            2'b01: ttrig_lvl = CW'(TTRIG_01);
            2'b10: ttrig_lvl = CW'(TTRIG_10);
            2'b11: ttrig_lvl = CW'(TTRIG_11);
            default: ttrig_lvl = CW'(TTRIG_00);
        endcase
    end

    // Without FIFOs each side degrades to a one-byte holding register
    always_comb begin
        tx_if.cap = fen_r ? CW'(FIFO_DEPTH) : CW'(1);
        rx_if.cap = fen_r ? CW'(FIFO_DEPTH) : CW'(1);
        tx_if.push = wr & (paddr == OFS_DATA);
        tx_if.wdata = pwdata[7:0];
        tx_if.pop = tx_take;
        tx_if.clear = txclr_r;
        rx_err_in = rx_parity_err | rx_framing_err | rx_break;
        rx_acc = rx_valid & ~rx_if.full & ~rxclr_r;
        rx_pop = rd & (paddr == OFS_DATA) & rdok_r & ~rxclr_r;
        rx_if.push = rx_valid;
        rx_if.wdata = {rx_break, rx_framing_err, rx_parity_err, rx_byte};
        rx_if.pop = rx_pop;
        rx_if.clear = rxclr_r;
    end
    assign tx_byte = tx_if.rdata;
    assign tx_avail = (tcnt != '0);

    // Parity, framing and break flags describe the byte at the head of the receive FIFO
    always_comb begin
        line_status = 8'h00;
        line_status[LS_DR] = (rcnt != '0);
        line_status[LS_OE] = ovr_r;
        if (rcnt != '0) begin
            line_status[LS_PE] = rx_if.rdata[8];
            line_status[LS_FE] = rx_if.rdata[9];
            line_status[LS_BI] = rx_if.rdata[10];
        end
        line_status[LS_THRE] = (tcnt == '0);
        line_status[LS_TEMT] = (tcnt == '0) & tx_shift_empty;
        line_status[LS_FERR] = (err_r != '0);
    end

    always_comb begin
        fen_nxt = fen_r;
        dma_nxt = dma_r;
        rtrig_nxt = rtrig_r;
        ttrig_nxt = ttrig_r;
        imask_nxt = imask_r;
        rxclr_nxt = 1'b0;
        txclr_nxt = 1'b0;
        if (wr & (paddr == OFS_IMASK)) begin
            imask_nxt = pwdata[3:0];
        end
        if (wr_fc) begin
            fen_nxt = pwdata[FC_EN];
            if (pwdata[FC_EN]) begin
                dma_nxt = pwdata[FC_DMA];
                rtrig_nxt = pwdata[FC_RTRIG +: 2];
                ttrig_nxt = pwdata[FC_TTRIG +: 2];
                rxclr_nxt = pwdata[FC_RXCLR];
                txclr_nxt = pwdata[FC_TXCLR];
            end
        end
        // A new overrun in the same cycle as the status read survives
        ovr_nxt = ovr_r & ~(rd & (paddr == OFS_LSTAT));
        if (rx_valid & rx_if.full) begin
            ovr_nxt = 1'b1;
        end
        err_nxt = err_r + CW'(rx_acc & rx_err_in)
                - CW'(rx_pop & (|rx_if.rdata[10:8]));
        if (rxclr_r) begin
            err_nxt = '0;
        end
        rdok_nxt = rdok_r;
        if (setup) begin
            rdok_nxt = (rcnt != '0);
        end
    end

    always_comb begin
        prdata_nxt = prdata_r;
        if (setup & ~pwrite) begin
            case (paddr)
                OFS_DATA: prdata_nxt = {24'h00_0000, rx_if.rdata[7:0]};
                OFS_IMASK: prdata_nxt = {28'h000_0000, imask_r};
                OFS_FCTRL: prdata_nxt = {24'h00_0000, rtrig_r, ttrig_r,
                                         dma_r, 2'b00, fen_r};
                OFS_LSTAT: prdata_nxt = {24'h00_0000, line_status};
                OFS_LEVEL: prdata_nxt = {16'h0000, 8'(tcnt), 8'(rcnt)};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        rx_cond = fen_r ? ((rcnt >= rtrig_lvl) | rx_timeout)
                        : (rcnt != '0);
        tx_cond = fen_r ? (tcnt < ttrig_lvl) : (tcnt == '0);
        irq_nxt = (imask_r[0] & rx_cond) | (imask_r[1] & tx_cond) |
                  (imask_r[2] & (|line_status[LS_BI:LS_OE]));
        if (mode1) begin
            txreq_n_nxt = txreq_n_r;
            if (tx_if.full) begin
                txreq_n_nxt = 1'b1;
            end else if (tcnt < ttrig_lvl) begin
                txreq_n_nxt = 1'b0;
            end
            rxreq_n_nxt = rxreq_n_r;
            if (rcnt == '0) begin
                rxreq_n_nxt = 1'b1;
            end else if ((rcnt >= rtrig_lvl) | rx_timeout) begin
                rxreq_n_nxt = 1'b0;
            end
        end else begin
            txreq_n_nxt = (tcnt != '0);
            rxreq_n_nxt = (rcnt == '0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fen_r <= FCTRL_RST[FC_EN];
            dma_r <= FCTRL_RST[FC_DMA];
            rtrig_r <= FCTRL_RST[FC_RTRIG +: 2];
            ttrig_r <= FCTRL_RST[FC_TTRIG +: 2];
            imask_r <= IMASK_RST;
            rxclr_r <= 1'b0;
            txclr_r <= 1'b0;
            ovr_r <= 1'b0;
            rdok_r <= 1'b0;
            err_r <= '0;
            prdata_r <= 32'h0000_0000;
            txreq_n_r <= 1'b1;
            rxreq_n_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            fen_r <= fen_nxt;
            dma_r <= dma_nxt;
            rtrig_r <= rtrig_nxt;
            ttrig_r <= ttrig_nxt;
            imask_r <= imask_nxt;
            rxclr_r <= rxclr_nxt;
            txclr_r <= txclr_nxt;
            ovr_r <= ovr_nxt;
            rdok_r <= rdok_nxt;
            err_r <= err_nxt;
            prdata_r <= prdata_nxt;
            txreq_n_r <= txreq_n_nxt;
            rxreq_n_r <= rxreq_n_nxt;
            irq_r <= irq_nxt;
        end
    end
    assign tx_dma_request_n = txreq_n_r;
    assign rx_dma_request_n = rxreq_n_r;
    assign int_request = irq_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    poll_quiet_a: assert property (
        imask_r[2:0] == 3'b000 |=> !int_request)
        else $error("interrupt raised with mask clear");
    rx_ready_a: assert property (
        rx_valid && rcnt == '0 && !rxclr_r |=> line_status[LS_DR])
        else $error("data ready not set after receive");
    break_kind_a: assert property (
        rx_valid && rx_break && rcnt == '0 && !rxclr_r |=> line_status[LS_BI])
        else $error("break not reported");
    tx_empty_a: assert property (
        tcnt == CW'(1) && tx_take && !tx_if.push && !txclr_r
        |=> line_status[LS_THRE])
        else $error("transmit empty bit not set");
    temt_both_a: assert property (
        !tx_shift_empty || tcnt != '0 |-> !line_status[LS_TEMT])
        else $error("shifter empty bit set too early");
    fifo_err_a: assert property (
        rx_acc && rx_parity_err |=> line_status[LS_FERR])
        else $error("fifo error bit missing");
    m0_tx_req_a: assert property (
        !mode1 && tcnt == '0 |=> !tx_dma_request_n)
        else $error("mode 0 transmit request not low");
    m0_rx_req_a: assert property (
        !mode1 && rcnt != '0 |=> !rx_dma_request_n)
        else $error("mode 0 receive request not low");
    m1_tx_full_a: assert property (
        mode1 && tx_if.full |=> tx_dma_request_n)
        else $error("mode 1 transmit request low when full");
    m1_rx_trig_a: assert property (
        mode1 && rcnt >= rtrig_lvl |=> !rx_dma_request_n)
        else $error("mode 1 receive request not low");
    tx_clear_a: assert property (
        wr_fc && pwdata[FC_EN] && pwdata[FC_TXCLR] |-> ##2 tcnt == '0)
        else $error("transmit fifo not cleared");
    rx_clear_a: assert property (
        wr_fc && pwdata[FC_EN] && pwdata[FC_RXCLR] |-> ##2 rcnt == '0)
        else $error("receive fifo not cleared");
    fc_guard_a: assert property (
        wr_fc && !pwdata[FC_EN] |=> dma_r == $past(dma_r))
        else $error("control bits written without enable");

    m1_rx_c: cover property (mode1 ##1 $fell(rx_dma_request_n));
    ovr_c: cover property (rx_valid && rx_if.full);
    txclr_c: cover property (txclr_r && tcnt != '0);
    poll_c: cover property (fen_r && imask_r == 4'h0 && line_status[LS_DR]);
endmodule : ufc_fifo_ctrl

//--- shared/ufc_fifo_if.sv
// Carrier between the control logic and one FIFO store.
// Assumes both ends share pclk and presetn.
`timescale 1ns/10ps
interface ufc_fifo_if #(parameter int W = 8, parameter int AW = 5);
    logic push;
    logic [W-1:0] wdata;
    logic pop;
    logic clear;
    logic [AW:0] cap;
    logic [W-1:0] rdata;
    logic [AW:0] count;
    logic full;
    modport ctrl(output push, wdata, pop, clear, cap,
                 input rdata, count, full);
    modport store(input push, wdata, pop, clear, cap,
                  output rdata, count, full);
endinterface : ufc_fifo_if

//--- shared/ufc_pkg.sv
// Constants for the UART FIFO control and DMA request block.
// Assumes a 32-bit APB register bus with word-aligned registers.
package ufc_pkg;
    localparam int ADDR_W = 8;
    localparam int FIFO_AW = 5;
    localparam int FIFO_DEPTH = 32;
    // Register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_IMASK = 8'h04;
    localparam logic [7:0] OFS_FCTRL = 8'h08;
    localparam logic [7:0] OFS_LSTAT = 8'h0C;
    localparam logic [7:0] OFS_LEVEL = 8'h10;
    // fifo_control fields
    localparam int FC_EN = 0;
    localparam int FC_RXCLR = 1;
    localparam int FC_TXCLR = 2;
    localparam int FC_DMA = 3;
    localparam int FC_TTRIG = 4;
    localparam int FC_RTRIG = 6;
    // line_status fields
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_PE = 2;
    localparam int LS_FE = 3;
    localparam int LS_BI = 4;
    localparam int LS_THRE = 5;
    localparam int LS_TEMT = 6;
    localparam int LS_FERR = 7;
    // Reset values
    localparam logic [7:0] FCTRL_RST = 8'h00;
    localparam logic [3:0] IMASK_RST = 4'h0;
    // Trigger levels in bytes
    localparam int RTRIG_00 = 8;
    localparam int RTRIG_01 = 16;
    localparam int RTRIG_10 = 24;
    localparam int RTRIG_11 = 28;
    localparam int TTRIG_00 = 16;
    localparam int TTRIG_01 = 8;
    localparam int TTRIG_10 = 24;
    localparam int TTRIG_11 = 30;
endpackage : ufc_pkg

//--- tb/uart_fifo_dma_control_test.sv
// Self-checking bench for the FIFO control and DMA request block.
// Assumes ufc_pkg, the design and ufc_line_model are compiled first.
`timescale 1ns/10ps
module uart_fifo_dma_control_test;
    import ufc_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q, r;
    logic rx_valid, rx_parity_err, rx_framing_err, rx_break, rx_timeout;
    logic [7:0] rx_byte, tx_byte;
    logic tx_take, tx_avail, tx_shift_empty;
    logic tx_dma_request_n, rx_dma_request_n, int_request;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    logic [8:0] rxq[$];
    logic [7:0] txq[$];
    logic [7:0] fcr_m = 8'h00;
    logic shift_e = 1'b1;
    int rt[4] = '{8, 16, 24, 28};
    int tt[4] = '{16, 8, 24, 30};

    always #2.5 pclk = ~pclk;

    ufc_fifo_ctrl i_ufc_fifo_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
        .rx_break(rx_break), .rx_timeout(rx_timeout), .tx_take(tx_take),
        .tx_byte(tx_byte), .tx_avail(tx_avail),
        .tx_shift_empty(tx_shift_empty),
        .tx_dma_request_n(tx_dma_request_n),
        .rx_dma_request_n(rx_dma_request_n), .int_request(int_request));
    ufc_line_model i_ufc_line_model (.pclk(pclk), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_parity_err(rx_parity_err),
        .rx_framing_err(rx_framing_err), .rx_break(rx_break),
        .tx_take(tx_take), .tx_byte(tx_byte), .tx_avail(tx_avail),
        .tx_shift_empty(tx_shift_empty));

    task end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Budget is a few thousand cycles; the ceiling leaves wide margin
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
        end
    endtask : chk_reg
    task chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: pin %b want %b", $time, got, exp);
        end
    endtask : chk_pin

    task settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        if (a == OFS_DATA) txq.push_back(d);
        if (a == OFS_FCTRL && d[0]) begin
            fcr_m = d & 8'hf9;
            if (d[1]) rxq.delete();
            if (d[2]) txq.delete();
        end else if (a == OFS_FCTRL) fcr_m[0] = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_reg(q, exp);
    endtask : rd
    task rx_in(input logic [7:0] b, input logic pe);
        i_ufc_line_model.send(b, pe);
        rxq.push_back({pe, b});
    endtask : rx_in
    task rx_pop();
        logic [8:0] h;
        h = rxq.pop_front();
        rd(OFS_DATA, {24'h0, h[7:0]});
    endtask : rx_pop
    task tk();
        logic [7:0] h;
        i_ufc_line_model.take();
        shift_e = 1'b0;
        h = txq.pop_front();
        chk_reg({24'h0, i_ufc_line_model.got_q.pop_front()}, {24'h0, h});
    endtask : tk
    function automatic logic [31:0] lsr_exp();
        logic [7:0] s;
        s = 8'h00;
        s[LS_DR] = rxq.size() != 0;
        if (rxq.size() != 0) begin
            s[LS_PE] = rxq[0][8];
            s[LS_BI] = rxq[0][7:0] == 8'h00;
        end
        foreach (rxq[i]) begin
            if (rxq[i][8] || rxq[i][7:0] == 8'h00) s[LS_FERR] = 1'b1;
        end
        s[LS_THRE] = txq.size() == 0;
        s[LS_TEMT] = txq.size() == 0 && shift_e;
        return {24'h0, s};
    endfunction : lsr_exp
    task pins0();
        settle();
        chk_pin(tx_dma_request_n, txq.size() != 0);
        chk_pin(rx_dma_request_n, rxq.size() == 0);
        chk_pin(int_request, 1'b0);
        rd(OFS_LSTAT, lsr_exp());
    endtask : pins0

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        rx_timeout = 1'b0;
        r = $urandom(32'h17ce_34c8);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        pins0();
        rd(OFS_FCTRL, {24'h0, FCTRL_RST});
        apb(1'b0, 8'h40, 32'h0);
        chk_pin(e, 1'b1);
        chk_reg(q, 32'h0000_0000);
        $display("test reset done");
        wr(OFS_FCTRL, 8'h01);
        for (int i = 0; i < 60; i++) begin
            r = $urandom();
            case (r[2:0])
                3'd0, 3'd1: if (rxq.size() < 30) rx_in(r[15:8], r[20] & r[21]);
                3'd2, 3'd6: if (rxq.size() != 0) rx_pop();
                3'd3, 3'd7: if (txq.size() < 30) wr(OFS_DATA, r[31:24]);
                3'd4: if (txq.size() != 0) tk();
                default: begin
                    i_ufc_line_model.idle();
                    shift_e = 1'b1;
                end
            endcase
            pins0();
        end
        while (txq.size() != 0) tk();
        $display("test mode0 random done");
        wr(OFS_IMASK, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_FCTRL, 8'h0b | 8'(c << 6));
            for (int k = 1; k < rt[c]; k++) rx_in(8'(k), 1'b0);
            settle();
            chk_pin(rx_dma_request_n, 1'b1);
            rx_in(8'hc3, 1'b0);
            settle();
            chk_pin(rx_dma_request_n, 1'b0);
            chk_pin(int_request, 1'b0);
            wr(OFS_IMASK, 8'h01);
            settle();
            chk_pin(int_request, 1'b1);
            wr(OFS_IMASK, 8'h00);
            rx_in(8'h3c, 1'b1);
            settle();
            chk_pin(rx_dma_request_n, 1'b0);
            rd(OFS_LEVEL, 32'(rt[c] + 1));
            rx_pop();
            wr(OFS_FCTRL, fcr_m | 8'h02);
            settle();
            rd(OFS_LEVEL, 32'h0000_0000);
            rd(OFS_FCTRL, {24'h0, fcr_m});
            chk_pin(rx_dma_request_n, 1'b1);
            rx_in(8'h81, 1'b0);
            rx_timeout <= 1'b1;
            settle();
            chk_pin(rx_dma_request_n, 1'b0);
            @(posedge pclk);
            rx_timeout <= 1'b0;
            rx_pop();
            settle();
            chk_pin(rx_dma_request_n, 1'b1);
        end
        $display("test rx trigger done");
        for (int c = 0; c < 4; c++) begin
            wr(OFS_FCTRL, 8'h0d | 8'(c << 4));
            settle();
            chk_pin(tx_dma_request_n, 1'b0);
            for (int k = 0; k < FIFO_DEPTH; k++) wr(OFS_DATA, 8'($urandom()));
            settle();
            chk_pin(tx_dma_request_n, 1'b1);
            rd(OFS_LEVEL, 32'h0000_2000);
            while (txq.size() > tt[c]) tk();
            settle();
            chk_pin(tx_dma_request_n, 1'b1);
            tk();
            settle();
            chk_pin(tx_dma_request_n, 1'b0);
            wr(OFS_IMASK, 8'h02);
            settle();
            chk_pin(int_request, 1'b1);
            wr(OFS_IMASK, 8'h00);
            wr(OFS_FCTRL, fcr_m | 8'h04);
            settle();
            rd(OFS_LEVEL, 32'h0000_0000);
            rd(OFS_FCTRL, {24'h0, fcr_m});
        end
        $display("test tx trigger done");
        wr(OFS_FCTRL, 8'hf6);
        rd(OFS_FCTRL, {24'h0, fcr_m});
        $display("test control done");
        // FIFOs now off: one-byte holding register, second byte overruns
        rx_in(8'h00, 1'b0);
        i_ufc_line_model.send(8'h22, 1'b0);
        wr(OFS_IMASK, 8'h04);
        settle();
        chk_pin(rx_dma_request_n, 1'b0);
        chk_pin(int_request, 1'b1);
        rd(OFS_LSTAT, lsr_exp() | 32'h0000_0002);
        rd(OFS_LSTAT, lsr_exp());
        wr(OFS_IMASK, 8'h00);
        rx_pop();
        settle();
        chk_pin(rx_dma_request_n, 1'b1);
        chk_pin(int_request, 1'b0);
        $display("test no fifo done");
        end_of_test();
    end
endmodule : uart_fifo_dma_control_test

//--- tb/ufc_line_model.sv
// Line-side partner: receive shifter strobes, transmit shifter takes.
// Assumes pclk from the bench; moved only through the tasks below.
`timescale 1ns/10ps
module ufc_line_model (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_parity_err,
    output logic rx_framing_err,
    output logic rx_break,
    output logic tx_take,
    input wire logic [7:0] tx_byte,
    input wire logic tx_avail,
    output logic tx_shift_empty
);
    logic [7:0] got_q[$];
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h5a;
        rx_parity_err = 1'b0;
        rx_framing_err = 1'b0;
        rx_break = 1'b0;
        tx_take = 1'b0;
        tx_shift_empty = 1'b1;
    end
    // Outside a strobe the data lines flip so stale values never match
    // An all-zero character is delivered as a line break
    task send(input logic [7:0] b, input logic pe);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_byte <= b;
        rx_parity_err <= pe;
        rx_break <= (b == 8'h00);
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
        rx_parity_err <= ~pe;
        rx_break <= (b != 8'h00);
    endtask : send
    // Head byte is sampled at the edge that pops it
    task take();
        @(posedge pclk);
        tx_take <= tx_avail;
        tx_shift_empty <= 1'b0;
        @(posedge pclk);
        got_q.push_back(tx_byte);
        tx_take <= 1'b0;
    endtask : take
    task idle();
        @(posedge pclk);
        tx_shift_empty <= 1'b1;
    endtask : idle
endmodule : ufc_line_model
